// File: verilog/peasf_pkg.sv
// package: constants and carrier types for the arithmetic status flag block
package peasf_pkg;
	// ------------------------------------------------------------
	// register map (byte offsets on apb)
	// ------------------------------------------------------------
	localparam logic [11:0] STATUS_OFF  = 12'h000; // pe_x_arith_status
	localparam logic [11:0] IRQ_STS_OFF = 12'h004; // sticky event bits
	localparam logic [11:0] IRQ_MSK_OFF = 12'h008; // event mask
	// ------------------------------------------------------------
	// field positions of the status word
	// ------------------------------------------------------------
	localparam int CMP_HI_POS   = 31; // newest compare result
	localparam int CMP_LO_POS   = 24; // oldest compare result
	localparam int BTF_POS      = 18; // bit_test_flag
	localparam int FIFO_POS     = 14; // shifter_fifo_half_flag
	localparam int SIGN_POS     = 13; // shifter sign
	localparam int ZERO_POS     = 12; // shifter_zero_flag
	localparam int OVF_POS      = 11; // shifter_overflow_flag
	localparam int AF_POS       = 10; // alu_float_flag
	// writable bits of the status word
	localparam logic [31:0] STATUS_WMASK = 32'hff043c00 & ~32'h00004000;
	localparam logic [31:0] STATUS_RST   = 32'h00000000;
	// ------------------------------------------------------------
	// shifter limits and fifo threshold
	// ------------------------------------------------------------
	localparam int FIELD_W       = 32; // fixed-point field width
	localparam logic [6:0] FIFO_HALF = 7'h20; // write pointer half mark
	localparam logic [5:0] LZ_FULL   = 6'h20; // count equal to whole word
	// ------------------------------------------------------------
	// event bit positions in the interrupt registers
	// ------------------------------------------------------------
	localparam int EV_CMP  = 0; // compare done
	localparam int EV_OVF  = 1; // shifter overflow raised
	localparam int EV_HALF = 2; // fifo reached half
	localparam int EV_N    = 3;
	localparam logic [2:0] EV_RST = 3'h0;
	// ------------------------------------------------------------
	// shifter operation kinds
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PEASF_SH_SHIFT = 3'b000, // plain shift, may overflow left
		PEASF_SH_BTST  = 3'b001, // bit test
		PEASF_SH_BMOD  = 3'b010, // bit set or clear
		PEASF_SH_FEXT  = 3'b011, // field extract
		PEASF_SH_LZ    = 3'b100, // count leading zeros or ones
		PEASF_SH_OTHER = 3'b101  // any other shifter op
	} peasf_shop_t;
	// shifter execution report
	typedef struct packed {
		logic        valid;    // one op this cycle
		peasf_shop_t op;       // kind of op
		logic        in_neg;   // operand negative
		logic        res_zero; // result equals zero
		logic        lost_msb; // significant bits pushed out left
		logic [7:0]  bitpos;   // addressed bit position
		logic [7:0]  flen;     // field length for extract
		logic [5:0]  lz_cnt;   // leading count result
	} peasf_shift_t;
	// alu execution report
	typedef struct packed {
		logic valid;   // one alu op this cycle
		logic is_fp;   // floating-point op
		logic is_cmp;  // op is a compare
		logic x_gt;    // x operand greater
	} peasf_alu_t;
	// system register bit test report
	typedef struct packed {
		logic valid;   // bit test or bit xor executed
		logic match;   // selected bits equal given value
	} peasf_btst_t;
	// whole block state
	typedef struct packed {
		logic [31:0]     status;   // status word
		logic [31:0]     cond;     // copy seen by conditions
		logic [EV_N-1:0] ev_sts;   // sticky events
		logic [EV_N-1:0] ev_msk;   // event mask
		logic            irq;      // interrupt output
		logic            pready;   // apb ready
		logic [31:0]     prdata;   // apb read data
		logic            pslverr;  // apb error
		logic            half_d;   // previous half flag
	} peasf_state_t;
endpackage

// File: verilog/peasf_flags.sv
// module: arithmetic status flags of processing element x with apb access
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
// How it works
// - eight compare history bits at 31..24
// - each compare shifts right, newest into 31
// - bit test flag follows system bit match
// - bit 14 read-only, fifo pointer at least 32
// - shifter sign follows operand sign
// - shifter zero follows zero result
// - zero set for out-of-field bit test
// - overflow set when bits lost left
// - overflow for out-of-field bit test/set/clear
// - overflow for extract past left edge
// - overflow when leading count equals 32
// - alu float flag follows alu op type
// - conditions see loaded word one cycle later
module peasf_flags #(
	parameter int FIFO_PTR_W = 7 // bit fifo write pointer width
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic [11:0]            paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire peasf_pkg::peasf_alu_t   alu_in,
	input  wire peasf_pkg::peasf_shift_t sh_in,
	input  wire peasf_pkg::peasf_btst_t  bt_in,
	input  wire logic [FIFO_PTR_W-1:0]  fifo_wptr,
	output logic [31:0]                 status_word,
	output logic [31:0]                 cond_word,
	output logic                        irq
);
	// ------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------
	// the pointer must reach the half mark of 32 and fit seven bits
	if (FIFO_PTR_W < 6 || FIFO_PTR_W > 7) begin : g_bad_ptr_w
		$error("fifo pointer width must be 6 or 7");
	end

	// ------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------
	peasf_pkg::peasf_state_t st_r;   // current state
	peasf_pkg::peasf_state_t st_nxt; // next state
	localparam int EV_W = peasf_pkg::EV_N; // event vector width

	// decoded apb strobes, fifo and shifter helpers
	logic        acc;    // access phase, answered next cycle
	logic        wr;     // write taking effect
	logic        rd;     // read taking effect
	logic        hit;    // mapped address
	logic [6:0]  wp;     // pointer widened to seven bits
	logic        half;   // fifo half full now
	logic        bt_out; // bit position outside field
	logic        fx_out; // extract past or across edge
	logic [8:0]  fx_end; // extract top position plus one
	logic        sh_ovf; // overflow from this shifter op
	logic        sh_zro; // zero from this shifter op
	logic [EV_W-1:0] ev_new; // events this cycle

	// ------------------------------------------------------------
	// combinational helpers
	// ------------------------------------------------------------
	always_comb begin
		acc    = psel && penable && !st_r.pready;
		wr     = acc && pwrite;
		rd     = acc && !pwrite;
		hit    = (paddr == peasf_pkg::STATUS_OFF) ||
		         (paddr == peasf_pkg::IRQ_STS_OFF) ||
		         (paddr == peasf_pkg::IRQ_MSK_OFF);
		wp     = 7'(fifo_wptr);
		half   = wp >= peasf_pkg::FIFO_HALF;
		bt_out = sh_in.bitpos >= 8'(peasf_pkg::FIELD_W);
		fx_end = 9'(sh_in.bitpos) + 9'(sh_in.flen);
		fx_out = fx_end > 9'(peasf_pkg::FIELD_W);
		sh_ovf = 1'b0;
		sh_zro = sh_in.res_zero;
		case (sh_in.op)
			peasf_pkg::PEASF_SH_SHIFT: begin
				sh_ovf = sh_in.lost_msb;
			end
			peasf_pkg::PEASF_SH_BTST: begin
				sh_ovf = bt_out;
				sh_zro = sh_in.res_zero || bt_out;
			end
			peasf_pkg::PEASF_SH_BMOD: begin
				sh_ovf = bt_out;
			end
			peasf_pkg::PEASF_SH_FEXT: begin
				sh_ovf = fx_out;
			end
			peasf_pkg::PEASF_SH_LZ: begin
				sh_ovf = sh_in.lz_cnt == peasf_pkg::LZ_FULL;
			end
			default: begin
				sh_ovf = 1'b0;
			end
		endcase
		ev_new = '0;
		ev_new[peasf_pkg::EV_CMP]  = alu_in.valid && alu_in.is_cmp;
		ev_new[peasf_pkg::EV_OVF]  = sh_in.valid && sh_ovf;
		ev_new[peasf_pkg::EV_HALF] = half && !st_r.half_d;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt         = st_r;
		st_nxt.pready  = acc;
		st_nxt.pslverr = acc && !hit;
		st_nxt.half_d  = half;
		// software write first, execution below overrides it
		if (wr && paddr == peasf_pkg::STATUS_OFF) begin
			st_nxt.status = (pwdata & peasf_pkg::STATUS_WMASK) |
			                (st_r.status & ~peasf_pkg::STATUS_WMASK);
		end
		if (wr && paddr == peasf_pkg::IRQ_MSK_OFF) begin
			st_nxt.ev_msk = pwdata[EV_W-1:0];
		end
		// write one clears, new events win
		if (wr && paddr == peasf_pkg::IRQ_STS_OFF) begin
			st_nxt.ev_sts = st_r.ev_sts & ~pwdata[EV_W-1:0];
		end
		st_nxt.ev_sts = st_nxt.ev_sts | ev_new;
		// compare history shift
		if (alu_in.valid && alu_in.is_cmp) begin
			st_nxt.status[peasf_pkg::CMP_HI_POS:peasf_pkg::CMP_LO_POS] =
				{alu_in.x_gt,
				 st_r.status[peasf_pkg::CMP_HI_POS:
				             peasf_pkg::CMP_LO_POS+1]};
		end
		if (alu_in.valid) begin
			st_nxt.status[peasf_pkg::AF_POS] = alu_in.is_fp;
		end
		if (bt_in.valid) begin
			st_nxt.status[peasf_pkg::BTF_POS] = bt_in.match;
		end
		if (sh_in.valid) begin
			st_nxt.status[peasf_pkg::SIGN_POS] = sh_in.in_neg;
			st_nxt.status[peasf_pkg::ZERO_POS] = sh_zro;
			st_nxt.status[peasf_pkg::OVF_POS]  = sh_ovf;
		end
		st_nxt.status[peasf_pkg::FIFO_POS] = half;
		// conditions read last cycle's word
		st_nxt.cond = st_r.status;
		st_nxt.irq  = |(st_nxt.ev_sts & st_nxt.ev_msk);
		// read data
		st_nxt.prdata = 32'h00000000;
		if (rd) begin
			case (paddr)
				peasf_pkg::STATUS_OFF: begin
					st_nxt.prdata = st_r.status;
				end
				peasf_pkg::IRQ_STS_OFF: begin
					st_nxt.prdata = 32'(st_r.ev_sts);
				end
				peasf_pkg::IRQ_MSK_OFF: begin
					st_nxt.prdata = 32'(st_r.ev_msk);
				end
				default: begin
					st_nxt.prdata = 32'h00000000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r         <= '0;
			st_r.status  <= peasf_pkg::STATUS_RST;
			st_r.cond    <= peasf_pkg::STATUS_RST;
			st_r.ev_sts  <= peasf_pkg::EV_RST;
			st_r.ev_msk  <= peasf_pkg::EV_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs straight from flops
	// ------------------------------------------------------------
	assign prdata      = st_r.prdata;
	assign pready      = st_r.pready;
	assign pslverr     = st_r.pslverr;
	assign status_word = st_r.status;
	assign cond_word   = st_r.cond;
	assign irq         = st_r.irq;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence cmp_seen_s;
		alu_in.valid && alu_in.is_cmp;
	endsequence

	cmp_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
		cmp_seen_s |=> status_word[31] == $past(alu_in.x_gt) &&
		status_word[30:24] == $past(status_word[31:25]))
		else $error("compare history did not shift");

	cmp_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(alu_in.valid && alu_in.is_cmp) &&
		!(psel && penable && pwrite && paddr == 12'h000 && !pready)
		|=> $stable(status_word[31:24]))
		else $error("compare history changed without cause");

	btf_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		bt_in.valid |=> status_word[18] == $past(bt_in.match))
		else $error("bit test flag wrong");

	fifo_half_a: assert property (@(posedge clk) disable iff (!rst_n)
		rst_n |=> status_word[14] == ($past(7'(fifo_wptr)) >= 7'h20))
		else $error("fifo half flag wrong");

	sign_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid |=> status_word[13] == $past(sh_in.in_neg))
		else $error("shifter sign wrong");

	zero_res_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid && sh_in.res_zero |=> status_word[12])
		else $error("shifter zero not set");

	zero_btst_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_BTST &&
		sh_in.bitpos >= 8'h20 |=> status_word[12] && status_word[11])
		else $error("out of field bit test flags wrong");

	ovf_shift_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_SHIFT
		|=> status_word[11] == $past(sh_in.lost_msb))
		else $error("shift overflow wrong");

	ovf_fext_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_FEXT &&
		(9'(sh_in.bitpos) + 9'(sh_in.flen) > 9'h020) |=> status_word[11])
		else $error("extract overflow missing");

	ovf_lz_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_LZ &&
		sh_in.lz_cnt == 6'h20 |=> status_word[11])
		else $error("leading count overflow missing");

	af_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
		alu_in.valid |=> status_word[10] == $past(alu_in.is_fp))
		else $error("alu float flag wrong");

	cond_lag_a: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1 |=> cond_word == $past(status_word))
		else $error("condition copy lag wrong");

	exec_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
		alu_in.valid && psel && penable && pwrite && !pready &&
		paddr == 12'h000 |=> status_word[10] == $past(alu_in.is_fp))
		else $error("software write beat execution");

	// ------------------------------------------------------------
	// shifter cases that the checks above leave open
	// ------------------------------------------------------------
	sequence bmod_out_s;
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_BMOD &&
		sh_in.bitpos >= 8'h20;
	endsequence

	sequence fext_inside_s;
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_FEXT &&
		(9'(sh_in.bitpos) + 9'(sh_in.flen) <= 9'h020);
	endsequence

	sequence plain_nonzero_s;
		sh_in.valid && sh_in.op != peasf_pkg::PEASF_SH_BTST &&
		!sh_in.res_zero;
	endsequence

	// bit set or clear outside the field raises overflow
	ovf_bmod_a: assert property (@(posedge clk) disable iff (!rst_n)
		bmod_out_s |=> status_word[11])
		else $error("bit modify overflow missing");

	// an extract inside the field leaves no overflow
	fext_clean_a: assert property (@(posedge clk) disable iff (!rst_n)
		fext_inside_s |=> !status_word[11])
		else $error("extract overflow set wrongly");

	// a non-zero result clears zero unless a bit test forces it
	zero_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
		plain_nonzero_s |=> !status_word[12])
		else $error("shifter zero not cleared");

	// ops with no overflow condition clear the flag
	ovf_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
		sh_in.valid && sh_in.op == peasf_pkg::PEASF_SH_OTHER
		|=> !status_word[11])
		else $error("shifter overflow not cleared");

	// ------------------------------------------------------------
	// register bus handshake
	// ------------------------------------------------------------
	sequence apb_take_s;
		psel && penable && !pready;
	endsequence

	sequence apb_bad_s;
		psel && penable && !pready && paddr != 12'h000 &&
		paddr != 12'h004 && paddr != 12'h008;
	endsequence

	// every taken access is answered on the next edge
	rdy_next_a: assert property (@(posedge clk) disable iff (!rst_n)
		apb_take_s |=> pready)
		else $error("access not answered");

	// ready stands for a single cycle
	rdy_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		pready |=> !pready)
		else $error("ready held too long");

	// an unmapped address is answered with an error
	err_unmap_a: assert property (@(posedge clk) disable iff (!rst_n)
		apb_bad_s |=> pready && pslverr)
		else $error("unmapped access without error");

	// read data is zero outside the answer cycle
	rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		!pready |-> prdata == 32'h00000000)
		else $error("read data outside answer cycle");

	// ------------------------------------------------------------
	// sticky events and software load
	// ------------------------------------------------------------
	// a compare sets its sticky bit even against a clear
	sticky_set_a: assert property (@(posedge clk) disable iff (!rst_n)
		alu_in.valid && alu_in.is_cmp |=> st_r.ev_sts[peasf_pkg::EV_CMP])
		else $error("compare event lost");

	// sticky bits only fall on a write to the event register
	sticky_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		!(wr && paddr == peasf_pkg::IRQ_STS_OFF)
		|=> (st_r.ev_sts & $past(st_r.ev_sts)) == $past(st_r.ev_sts))
		else $error("sticky bit fell without clear");

	// a load with no execution in the cycle lands in the history
	sequence quiet_load_s;
		psel && penable && pwrite && !pready && paddr == 12'h000 &&
		!alu_in.valid && !sh_in.valid && !bt_in.valid;
	endsequence

	load_hist_a: assert property (@(posedge clk) disable iff (!rst_n)
		quiet_load_s |=> status_word[31:24] == $past(pwdata[31:24]))
		else $error("software load of history lost");
endmodule

// File: testbench/tb_peasf_flags.sv
// testbench: self-checking bench for the arithmetic status flag block
`timescale 1ns/1ps
module tb_peasf_flags;
	// ------------------------------------------------------------
	// signals, counters and the shifter row table
	// ------------------------------------------------------------
	typedef struct packed {
		peasf_pkg::peasf_shift_t s; // shifter report
		logic [2:0]              e; // expected sign, zero, overflow
	} peasf_row_t;
	localparam logic [9:0] PAT = 10'h2ce; // compare outcomes
	logic                    clk;
	logic                    rst_n;
	logic [11:0]             paddr;
	logic                    psel;
	logic                    penable;
	logic                    pwrite;
	logic [31:0]             pwdata;
	logic [31:0]             prdata;
	logic                    pready;
	logic                    pslverr;
	peasf_pkg::peasf_alu_t   alu_in;
	peasf_pkg::peasf_shift_t sh_in;
	peasf_pkg::peasf_btst_t  bt_in;
	logic [6:0]              fifo_wptr;
	logic [31:0]             status_word;
	logic [31:0]             cond_word;
	logic                    irq;
	int                      failures = 0;
	int                      tests_run = 0;
	int                      cycles = 0;
	logic [31:0]             rd;     // last read data
	logic                    err;    // last slave error
	logic [31:0]             cd_rdy; // condition copy in answer cycle
	logic [7:0]              hist;   // expected compare history
	peasf_row_t              rows [10];
	peasf_flags #(.FIFO_PTR_W(7)) dut (.clk(clk), .rst_n(rst_n),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alu_in(alu_in), .sh_in(sh_in), .bt_in(bt_in),
		.fifo_wptr(fifo_wptr), .status_word(status_word),
		.cond_word(cond_word), .irq(irq));
	// clock of 8 ns and a hang guard
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			give_verdict();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// apb transfer; ax pulses an alu op at the edge the write is taken
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input peasf_pkg::peasf_alu_t ax);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		alu_in  <= ax;
		@(posedge clk);
		alu_in  <= '0;
		// hold the request until ready is seen high at a rising edge
		while (pready !== 1'b1)
			@(posedge clk);
		rd     = prdata;
		err    = pslverr;
		cd_rdy = cond_word;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// one cycle of execution reports, then look once settled
	task automatic exe(input peasf_pkg::peasf_alu_t a,
		input peasf_pkg::peasf_shift_t s, input peasf_pkg::peasf_btst_t b);
		@(posedge clk);
		alu_in <= a;
		sh_in  <= s;
		bt_in  <= b;
		@(posedge clk);
		alu_in <= '0;
		sh_in  <= '0;
		bt_in  <= '0;
		@(negedge clk);
	endtask
	function automatic peasf_row_t mk(input logic [2:0] op,
		input logic [2:0] nzl, input logic [7:0] bp, input logic [7:0] fl,
		input logic [5:0] lz, input logic [2:0] e);
		mk = {1'b1, op, nzl, bp, fl, lz, e};
	endfunction
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		alu_in = '0;
		sh_in = '0;
		bt_in = '0;
		fifo_wptr = 7'h00;
		rows[0] = mk(3'h0, 3'b101, 8'h00, 8'h00, 6'h00, 3'b101);
		rows[1] = mk(3'h0, 3'b010, 8'h00, 8'h00, 6'h00, 3'b010);
		rows[2] = mk(3'h1, 3'b000, 8'h20, 8'h00, 6'h00, 3'b011);
		rows[3] = mk(3'h1, 3'b000, 8'h1f, 8'h00, 6'h00, 3'b000);
		rows[4] = mk(3'h2, 3'b000, 8'h28, 8'h00, 6'h00, 3'b001);
		rows[5] = mk(3'h3, 3'b000, 8'h18, 8'h08, 6'h00, 3'b000);
		rows[6] = mk(3'h3, 3'b000, 8'h19, 8'h08, 6'h00, 3'b001);
		rows[7] = mk(3'h4, 3'b000, 8'h00, 8'h00, 6'h20, 3'b001);
		rows[8] = mk(3'h4, 3'b010, 8'h00, 8'h00, 6'h1f, 3'b010);
		rows[9] = mk(3'h5, 3'b100, 8'h00, 8'h00, 6'h00, 3'b100);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		chk("status_rst", 32'h0, status_word);
		chk("irq_rst", 32'h0, {31'h0, irq});
		// shifter sign, zero and overflow from the row table
		foreach (rows[i]) begin
			exe('0, rows[i].s, '0);
			chk("sh_flags", {29'h0, rows[i].e}, {29'h0, status_word[13:11]});
		end
		exe('0, '0, 2'b11);
		chk("btf_set", 32'h1, {31'h0, status_word[18]});
		exe('0, '0, 2'b10);
		chk("btf_clr", 32'h0, {31'h0, status_word[18]});
		// software load, read-only fifo bit, condition lag
		apb(1'b1, peasf_pkg::STATUS_OFF, 32'hffffffff, '0);
		chk("cond_lag", 32'h00002000, cd_rdy);
		@(negedge clk);
		chk("cond_new", peasf_pkg::STATUS_WMASK, cond_word);
		apb(1'b0, peasf_pkg::STATUS_OFF, 32'h0, '0);
		chk("status_rd", peasf_pkg::STATUS_WMASK, rd);
		apb(1'b1, peasf_pkg::STATUS_OFF, 32'h0, '0);
		// compare history shifting and alu float flag
		hist = 8'h00;
		for (int i = 0; i < 10; i++) begin
			exe({1'b1, i[0], i != 4, PAT[i]}, '0, '0);
			if (i != 4)
				hist = {PAT[i], hist[7:1]};
			chk("cmp_hist", {24'h0, hist}, {24'h0, status_word[31:24]});
			chk("alu_fp", {31'h0, i[0]}, {31'h0, status_word[10]});
		end
		// execution beats a software write in the same cycle
		apb(1'b1, peasf_pkg::STATUS_OFF, 32'h0, 4'b1111);
		@(negedge clk);
		chk("prio_cmp", 32'h1, {31'h0, status_word[31]});
		chk("prio_fp", 32'h1, {31'h0, status_word[10]});
		apb(1'b0, 12'h00c, 32'h0, '0);
		chk("unmap_err", 32'h1, {31'h0, err});
		chk("unmap_rd", 32'h0, rd);
		// events, mask and interrupt
		apb(1'b1, peasf_pkg::IRQ_STS_OFF, 32'h7, '0);
		apb(1'b1, peasf_pkg::IRQ_MSK_OFF, 32'h0, '0);
		@(posedge clk);
		fifo_wptr <= 7'h1f;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("fifo_31", 32'h0, {31'h0, status_word[14]});
		@(posedge clk);
		fifo_wptr <= 7'h20;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk("fifo_32", 32'h1, {31'h0, status_word[14]});
		exe('0, rows[0].s, '0);
		exe(4'b1011, '0, '0);
		apb(1'b0, peasf_pkg::IRQ_STS_OFF, 32'h0, '0);
		chk("sticky", 32'h7, {29'h0, rd[2:0]});
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, peasf_pkg::IRQ_MSK_OFF, 32'h1, '0);
		@(negedge clk);
		chk("irq_on", 32'h1, {31'h0, irq});
		apb(1'b1, peasf_pkg::IRQ_STS_OFF, 32'h1, '0);
		@(negedge clk);
		chk("irq_off", 32'h0, {31'h0, irq});
		apb(1'b0, peasf_pkg::IRQ_STS_OFF, 32'h0, '0);
		chk("sticky_w1c", 32'h6, {29'h0, rd[2:0]});
		apb(1'b1, peasf_pkg::IRQ_MSK_OFF, 32'h7, '0);
		// reset in mid-run, fifo bit returns on first edge
		@(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		chk("status_rst2", 32'h0, status_word);
		chk("irq_rst2", 32'h0, {31'h0, irq});
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk("fifo_rst2", 32'h1, {31'h0, status_word[14]});
		give_verdict();
	end
endmodule
